// ### rtl/pdm_cfg.svh
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH
// ==========================================================================
// widths of the memory bus
`define PDM_ADDR_W        22
`define PDM_DATA_W        16
// ==========================================================================
// sequence and mode-key addresses
`define PDM_TOP_ADDR      22'h3F_FFFF
`define PDM_KEY_SLEEP     22'h3F_FFFF
`define PDM_KEY_4M        22'h37_FFFF
`define PDM_KEY_8M        22'h2F_FFFF
`define PDM_KEY_16M       22'h27_FFFF
`define PDM_DONT_CARE     16'h0000
`define PDM_SEQ_LAST      3'h5
// ==========================================================================
// timing: one access, one standby gap and the wake recovery, in ns and in cycles
`define PDM_CLK_NS        20
`define PDM_T_CYCLE_NS    70
`define PDM_T_GAP_NS      70
`define PDM_T_WAKE_NS     200
`define PDM_ACC_CYC       ((`PDM_T_CYCLE_NS + `PDM_CLK_NS - 1) / `PDM_CLK_NS)
`define PDM_GAP_CYC       ((`PDM_T_GAP_NS + `PDM_CLK_NS - 1) / `PDM_CLK_NS)
`define PDM_WAKE_CYC      ((`PDM_T_WAKE_NS + `PDM_CLK_NS - 1) / `PDM_CLK_NS)
`define PDM_CNT_W         4
`endif

// ### rtl/pdm_pkg.sv
`include "pdm_cfg.svh"
package pdm_pkg;
  // ========================================================================
  // user commands
  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_PROGRAM, OP_SLEEP, OP_WAKE} pdm_op_t;
  // retention mode kept while powered down; part_a is the smaller partial
  typedef enum logic [1:0] {MODE_SLEEP, MODE_PART_A, MODE_PART_B} pdm_mode_t;
  // access engine states
  typedef enum logic [1:0] {E_IDLE, E_STROBE, E_GAP} pdm_eng_st_t;
  // controller states
  typedef enum logic [2:0] {M_IDLE, M_USER, M_PROG, M_PD, M_WAKE} pdm_st_t;
  // ========================================================================
  // access engine state
  typedef struct packed {
    pdm_eng_st_t             st;
    logic [`PDM_CNT_W-1:0]   cnt;
    logic                    wr;
    logic [`PDM_ADDR_W-1:0]  addr;
    logic [`PDM_DATA_W-1:0]  wdata;
    logic [`PDM_DATA_W-1:0]  rdata;
    logic                    cs_n;
    logic                    we_n;
    logic                    oe_n;
    logic                    dq_oe;
  } pdm_eng_q_t;
  // controller state
  typedef struct packed {
    pdm_st_t                 st;
    logic                    issued;
    logic [2:0]              step;
    logic [`PDM_CNT_W-1:0]   cnt;
    logic                    wr;
    logic [`PDM_ADDR_W-1:0]  addr;
    logic [`PDM_DATA_W-1:0]  wdata;
    logic [`PDM_DATA_W-1:0]  first_read_value;
    logic [`PDM_DATA_W-1:0]  key_read_value;
    pdm_mode_t               pend_mode;
    pdm_mode_t               mode;
    logic                    pd_sel;
    logic                    rsp_valid;
    logic [`PDM_DATA_W-1:0]  rsp_rdata;
  } pdm_q_t;
endpackage

// ### rtl/pdm_bus_if.sv
`timescale 1ns/1ps
`include "pdm_cfg.svh"
// ==========================================================================
// one access request from the sequencer to the access engine
interface pdm_bus_if;
  logic                   req_valid;  // access wanted
  logic                   req_ready;  // engine idle, memory in standby
  logic                   req_wr;     // 1 write, 0 read
  logic [`PDM_ADDR_W-1:0] req_addr;   // word address
  logic [`PDM_DATA_W-1:0] req_wdata;  // write data
  logic                   rsp_valid;  // access and its standby gap done
  logic [`PDM_DATA_W-1:0] rsp_rdata;  // word captured by a read
  modport ctrl (output req_valid, req_wr, req_addr, req_wdata,
                input  req_ready, rsp_valid, rsp_rdata);
  modport eng  (input  req_valid, req_wr, req_addr, req_wdata,
                output req_ready, rsp_valid, rsp_rdata);
endinterface // pdm_bus_if

// ### rtl/pdm_cycle.sv
`timescale 1ns/1ps
`include "pdm_cfg.svh"
// ==========================================================================
// single asynchronous access: strobe, then a standby gap with select high
module pdm_cycle
(
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  // request side
  pdm_bus_if.eng                      bus,
  // memory pins
  output logic [`PDM_ADDR_W-1:0]      mem_addr_o,
  output logic                        chip_select_n_o,
  output logic                        mem_we_n_o,
  output logic                        mem_oe_n_o,
  output logic [`PDM_DATA_W-1:0]      mem_dq_o,
  output logic                        mem_dq_oe_o,
  input  wire logic [`PDM_DATA_W-1:0] mem_dq_i
);
  import pdm_pkg::*;

  localparam logic [`PDM_CNT_W-1:0] ACC_LAST = `PDM_CNT_W'(`PDM_ACC_CYC - 1);
  localparam logic [`PDM_CNT_W-1:0] GAP_LAST = `PDM_CNT_W'(`PDM_GAP_CYC - 1);
  localparam pdm_eng_q_t RST_Q = '{st: E_IDLE, cnt: '0, wr: 1'b0, addr: '0,
                                   wdata: '0, rdata: '0, cs_n: 1'b1,
                                   we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0};

  pdm_eng_q_t q;       // registered state
  pdm_eng_q_t next_q;  // next state

  // ========================================================================
  // handshake
  assign bus.req_ready = (q.st == E_IDLE);
  assign bus.rsp_valid = (q.st == E_GAP) && (q.cnt == GAP_LAST);
  assign bus.rsp_rdata = q.rdata;

  // ========================================================================
  // next state
  always_comb
  begin
    next_q = q;
    case (q.st)
      E_IDLE:
      begin
        // launch: address, select and strobe move on the same edge
        if (bus.req_valid)
        begin
          next_q.st    = E_STROBE;
          next_q.cnt   = '0;
          next_q.wr    = bus.req_wr;
          next_q.addr  = bus.req_addr;
          next_q.wdata = bus.req_wdata;
          next_q.cs_n  = 1'b0;
          next_q.we_n  = ~bus.req_wr;
          next_q.oe_n  = bus.req_wr;
          next_q.dq_oe = bus.req_wr;
        end
      end
      E_STROBE:
      begin
        if (q.cnt == ACC_LAST)
        begin
          // read data sampled just before the strobes are released
          if (!q.wr)
          begin
            next_q.rdata = mem_dq_i;
          end
          // select and write end together; data is kept one more cycle
          next_q.st   = E_GAP;
          next_q.cnt  = '0;
          next_q.cs_n = 1'b1; // R06
          next_q.we_n = 1'b1;
          next_q.oe_n = 1'b1;
        end
        else
        begin
          next_q.cnt = q.cnt + 1'b1;
        end
      end
      E_GAP:
      begin
        // standby between accesses, so the next one is a fresh access
        next_q.dq_oe = 1'b0;
        if (q.cnt == GAP_LAST)
        begin
          next_q.st = E_IDLE; // R06
        end
        else
        begin
          next_q.cnt = q.cnt + 1'b1;
        end
      end
      default:
      begin
        next_q = RST_Q;
      end
    endcase
  end

  // ========================================================================
  // state register
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q <= RST_Q;
    end
    else
    begin
      q <= next_q;
    end
  end

  // pins straight from flops
  assign mem_addr_o      = q.addr;
  assign chip_select_n_o = q.cs_n;
  assign mem_we_n_o      = q.we_n;
  assign mem_oe_n_o      = q.oe_n;
  assign mem_dq_o        = q.wdata;
  assign mem_dq_oe_o     = q.dq_oe;
endmodule // pdm_cycle

// ### rtl/pdm_ctrl.sv
`timescale 1ns/1ps
`include "pdm_cfg.svh"
// Notes on behaviour
// R01: low select holds idle; high resumes
// R02: sleep is default, lowest power, loses data
// R03: sleep needs no programming after power-up
// R04: 32M partials keep 3FFFFh or 7FFFFh
// R05: 64M partials keep 7FFFFh or FFFFFh
// R06: six accesses, standby between each
// R07: first access reads top address
// R08: accesses two, three write back first value
// R09: misaddressed write two/three becomes normal write
// R10: accesses four, five write top, data ignored
// R11: misaddressed write four/five cancels, data lost
// R12: sixth reads mode key; mode adopted
// R13: key address bits A20:A19 pick mode
// R14: program partial mode before regular traffic
// R15: power-down only from standby, data tristated
// R16: recogniser returns idle; mode kept
// ==========================================================================
// host controller: user reads/writes, mode programming, power-down control
module pdm_ctrl
#(
  parameter bit DENSITY_64M = 1'b1  // 1: 64M part, 0: 32M part
)
(
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  // user command
  input  wire logic                   cmd_valid_i,
  output logic                        cmd_ready_o,
  input  wire pdm_pkg::pdm_op_t       cmd_op_i,
  input  wire logic [`PDM_ADDR_W-1:0] cmd_addr_i,
  input  wire logic [`PDM_DATA_W-1:0] cmd_wdata_i,
  input  wire pdm_pkg::pdm_mode_t     cmd_mode_i,
  // user response and status
  output logic                        rsp_valid_o,
  output logic [`PDM_DATA_W-1:0]      rsp_rdata_o,
  output pdm_pkg::pdm_mode_t          mode_o,
  output logic                        powered_down_o,
  // memory pins
  output logic [`PDM_ADDR_W-1:0]      mem_addr_o,
  output logic                        chip_select_n_o,
  output logic                        power_down_select_o,
  output logic                        mem_we_n_o,
  output logic                        mem_oe_n_o,
  output logic                        mem_lb_n_o,
  output logic                        mem_ub_n_o,
  output logic [`PDM_DATA_W-1:0]      mem_dq_o,
  output logic                        mem_dq_oe_o,
  input  wire logic [`PDM_DATA_W-1:0] mem_dq_i
);
  import pdm_pkg::*;

  localparam logic [`PDM_CNT_W-1:0] WAKE_LAST = `PDM_CNT_W'(`PDM_WAKE_CYC - 1);
  // sleep after reset: the part powers up in sleep, nothing to program
  localparam pdm_q_t RST_Q = '{st: M_IDLE, issued: 1'b0, step: '0, cnt: '0,
                               wr: 1'b0, addr: '0, wdata: '0,
                               first_read_value: '0, key_read_value: '0,
                               pend_mode: MODE_SLEEP, mode: MODE_SLEEP,
                               pd_sel: 1'b1, rsp_valid: 1'b0, rsp_rdata: '0};

  pdm_q_t q;       // registered state
  pdm_q_t next_q;  // next state
  pdm_bus_if bus (); // sequencer to access engine

  // ========================================================================
  // mode key address; A21 and A18..A0 ones, A20:A19 pick the mode
  function automatic logic [`PDM_ADDR_W-1:0] key_addr(input pdm_mode_t m);
    logic [`PDM_ADDR_W-1:0] a;
    case (m)
      MODE_PART_A: a = DENSITY_64M ? `PDM_KEY_8M  : `PDM_KEY_4M;  // R13 R04 R05
      MODE_PART_B: a = DENSITY_64M ? `PDM_KEY_16M : `PDM_KEY_8M;  // R13 R04 R05
      default:     a = `PDM_KEY_SLEEP; // R13
    endcase
    return a;
  endfunction

  // ========================================================================
  // address of each step of the mode program
  function automatic logic [`PDM_ADDR_W-1:0] seq_addr(input logic [2:0] s,
                                                      input pdm_mode_t m);
    return (s == `PDM_SEQ_LAST) ? key_addr(m) : `PDM_TOP_ADDR; // R07 R08 R10 R12
  endfunction

  // ========================================================================
  // command acceptance: wake is the only command taken while powered down
  always_comb
  begin
    case (q.st)
      M_IDLE:  cmd_ready_o = (cmd_op_i != OP_WAKE);
      M_PD:    cmd_ready_o = (cmd_op_i == OP_WAKE);
      default: cmd_ready_o = 1'b0;
    endcase
  end

  // ========================================================================
  // request towards the engine; one access per request
  always_comb
  begin
    bus.req_valid = ((q.st == M_USER) || (q.st == M_PROG)) && !q.issued;
    bus.req_wr    = q.wr;
    bus.req_addr  = q.addr;
    bus.req_wdata = q.wdata;
  end

  // ========================================================================
  // sequencer next state
  always_comb
  begin
    next_q           = q;
    next_q.rsp_valid = 1'b0;
    if (bus.req_valid && bus.req_ready)
    begin
      next_q.issued = 1'b1;
    end
    case (q.st)
      M_IDLE:
      begin
        if (cmd_valid_i && cmd_ready_o)
        begin
          case (cmd_op_i)
            OP_READ, OP_WRITE:
            begin
              next_q.st     = M_USER;
              next_q.issued = 1'b0;
              next_q.wr     = (cmd_op_i == OP_WRITE);
              next_q.addr   = cmd_addr_i;
              next_q.wdata  = cmd_wdata_i;
            end
            OP_PROGRAM:
            begin
              // first access: read of the top address
              next_q.st        = M_PROG; // R14
              next_q.issued    = 1'b0;
              next_q.step      = '0;
              next_q.pend_mode = cmd_mode_i;
              next_q.wr        = 1'b0;                         // R07
              next_q.addr      = seq_addr(3'h0, cmd_mode_i);   // R07
              next_q.wdata     = `PDM_DONT_CARE;
            end
            OP_SLEEP:
            begin
              // idle here means the engine is in standby, select high
              next_q.st     = M_PD;   // R15
              next_q.pd_sel = 1'b0;   // R01
            end
            default:
            begin
              next_q.st = M_IDLE;
            end
          endcase
        end
      end
      M_USER:
      begin
        if (bus.rsp_valid)
        begin
          next_q.st        = M_IDLE;
          next_q.rsp_valid = 1'b1;
          next_q.rsp_rdata = q.wr ? q.rsp_rdata : bus.rsp_rdata;
        end
      end
      M_PROG:
      begin
        if (bus.rsp_valid)
        begin
          next_q.issued = 1'b0;
          next_q.step   = q.step + 3'h1;
          next_q.addr   = seq_addr(q.step + 3'h1, q.pend_mode); // R06
          // steps 0,1 lead into write-backs of the first word
          next_q.wr     = (q.step != 3'h4); // R06 R12
          next_q.wdata  = (q.step == 3'h0) ? bus.rsp_rdata       // R08
                        : (q.step == 3'h1) ? q.first_read_value  // R08
                        : `PDM_DONT_CARE;                        // R10
          if (q.step == 3'h0)
          begin
            next_q.first_read_value = bus.rsp_rdata; // R07
          end
          if (q.step == `PDM_SEQ_LAST)
          begin
            // key read done: the part now holds the new mode
            next_q.key_read_value = bus.rsp_rdata; // R12
            next_q.mode           = q.pend_mode;   // R12
            next_q.st             = M_IDLE;        // R16
            next_q.step           = '0;
            next_q.rsp_valid      = 1'b1;
            next_q.rsp_rdata      = bus.rsp_rdata;
          end
        end
      end
      M_PD:
      begin
        // select held low keeps the part idle until wake
        if (cmd_valid_i && cmd_ready_o)
        begin
          next_q.st     = M_WAKE;
          next_q.pd_sel = 1'b1; // R01
          next_q.cnt    = '0;
        end
      end
      M_WAKE:
      begin
        // recovery before the first access after power-down
        if (q.cnt == WAKE_LAST)
        begin
          next_q.st = M_IDLE;
        end
        else
        begin
          next_q.cnt = q.cnt + 1'b1;
        end
      end
      default:
      begin
        next_q = RST_Q;
      end
    endcase
  end

  // ========================================================================
  // state register
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q <= RST_Q; // R03
    end
    else
    begin
      q <= next_q;
    end
  end

  // ========================================================================
  // access engine; in power-down it sits idle so the data pins float
  pdm_cycle u_cycle
  (
    .sys_clk_i       (sys_clk_i),
    .rstn_i          (rstn_i),
    .bus             (bus),
    .mem_addr_o      (mem_addr_o),
    .chip_select_n_o (chip_select_n_o),
    .mem_we_n_o      (mem_we_n_o),
    .mem_oe_n_o      (mem_oe_n_o),
    .mem_dq_o        (mem_dq_o),
    .mem_dq_oe_o     (mem_dq_oe_o),
    .mem_dq_i        (mem_dq_i)
  );

  // ========================================================================
  // outputs; word accesses only, so both byte strobes stay on
  assign mem_lb_n_o          = 1'b0;
  assign mem_ub_n_o          = 1'b0;
  assign power_down_select_o = q.pd_sel;
  assign powered_down_o      = (q.st == M_PD);
  assign mode_o              = q.mode;
  assign rsp_valid_o         = q.rsp_valid;
  assign rsp_rdata_o         = q.rsp_rdata;
endmodule // pdm_ctrl

// ### bench/pdm_ctrl_checker.sv
`timescale 1ns/1ps
`include "pdm_cfg.svh"
// ==========================================================================
// pin-level checks on the controller
module pdm_chk
(
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              rstn_i,
  // user side
  input wire logic              cmd_valid_i,
  input wire logic              cmd_ready_o,
  input wire pdm_pkg::pdm_op_t  cmd_op_i,
  input wire logic              rsp_valid_o,
  input wire pdm_pkg::pdm_mode_t mode_o,
  input wire logic              powered_down_o,
  // memory pins
  input wire logic [21:0]       mem_addr_o,
  input wire logic              chip_select_n_o,
  input wire logic              power_down_select_o,
  input wire logic              mem_we_n_o,
  input wire logic              mem_oe_n_o,
  input wire logic              mem_dq_oe_o
);
  import pdm_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // one access: select low four cycles, then released
  sequence s_strobe;
    !chip_select_n_o [*4] ##1 chip_select_n_o;
  endsequence
  // a program command taken
  sequence s_take_prog;
    cmd_valid_i && cmd_ready_o && cmd_op_i == OP_PROGRAM;
  endsequence
  // first access of a program reads the top address
  sequence s_top_read;
    !chip_select_n_o && mem_we_n_o && mem_addr_o == `PDM_TOP_ADDR;
  endsequence
  pd_standby_a: assert property ($fell(power_down_select_o) |-> chip_select_n_o)
    else $error("power-down entered while selected");
  pd_float_a: assert property (!power_down_select_o |-> chip_select_n_o && !mem_dq_oe_o)
    else $error("bus active during power-down");
  pd_status_a: assert property (!power_down_select_o |-> powered_down_o)
    else $error("status low while powered down");
  pd_refuse_a: assert property (powered_down_o && cmd_op_i != OP_WAKE |-> !cmd_ready_o)
    else $error("command accepted in power-down");
  strobe_len_a: assert property ($fell(chip_select_n_o) |-> s_strobe)
    else $error("select strobe length wrong");
  gap_len_a: assert property ($rose(chip_select_n_o) |-> chip_select_n_o [*4])
    else $error("standby gap too short");
  prog_start_a: assert property (s_take_prog |-> ##[1:3] s_top_read)
    else $error("program did not start with top read");
  write_drive_a: assert property (!mem_we_n_o |-> mem_dq_oe_o && !chip_select_n_o)
    else $error("write without data drive");
  read_float_a: assert property (!mem_oe_n_o |-> !mem_dq_oe_o && mem_we_n_o)
    else $error("host drives during read");
  mode_change_a: assert property ($changed(mode_o) |-> rsp_valid_o)
    else $error("mode changed without response");
endmodule // pdm_chk
bind pdm_ctrl pdm_chk chk_u (.sys_clk_i, .rstn_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i,
  .rsp_valid_o, .mode_o, .powered_down_o, .mem_addr_o, .chip_select_n_o,
  .power_down_select_o, .mem_we_n_o, .mem_oe_n_o, .mem_dq_oe_o);

// ### bench/pdm_mem_model.sv
`timescale 1ns/1ps
`include "pdm_cfg.svh"
// ==========================================================================
// behavioural memory: mode recogniser, retention and power-down
module pdm_mem_model
#(
  parameter bit DENSITY_64M = 1'b1  // 1: 64M keys, 0: 32M keys
)
(
  // pins from the host
  input  wire logic        clk_i,
  input  wire logic [21:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        pds_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [15:0] dq_i,
  // read drive and status
  output logic [15:0]      dq_o,
  output logic [1:0]       mode_o,
  output logic [2:0]       step_o,
  output logic             err_o
);
  logic [15:0] mem [int];   // sparse array
  logic [15:0] first_read_value;
  logic [21:0] a;           // address of the open access
  logic [15:0] d;           // data of the open access
  logic        wr;          // open access is a write
  logic        pcs = 1'b1;  // select at the last edge
  logic        ppd = 1'b1;  // power-down select at the last edge
  int          q[$];        // words dropped on entry
  initial {dq_o, mode_o, step_o, err_o} = '0;
  // missing words read as zero, so lost data is visible
  function automatic logic [15:0] rdw(input int x);
    return mem.exists(x) ? mem[x] : 16'h0000;
  endfunction
  // highest retained word of a partial mode
  function automatic int lim(input logic [1:0] m);
    return DENSITY_64M ? (m == 2'h1 ? 'h7_FFFF : 'hF_FFFF) : (m == 2'h1 ? 'h3_FFFF : 'h7_FFFF);
  endfunction
  // falling edge sampling keeps clear of the host's rising edge updates
  always @(negedge clk_i)
  begin
    if (!cs_n_i && pds_i)
    begin
      {wr, a, d} = {!we_n_i, addr_i, dq_i};
      dq_o = (oe_n_i || !we_n_i) ? ~dq_o : rdw(a);
    end
    else
      dq_o = ~dq_o;  // released bus never holds its last value
    if (!pcs && cs_n_i)
    begin
      if (wr && step_o != 3'h3 && step_o != 3'h4)
        mem[a] = d;
      if (!wr && a == `PDM_TOP_ADDR && step_o != 3'h5)
        step_o = 3'h0;
      if (step_o == 3'h0)
        first_read_value = rdw(a);
      case (step_o)
        3'h0: step_o = (!wr && a == `PDM_TOP_ADDR) ? 3'h1 : 3'h0;
        3'h1, 3'h2: step_o = (wr && a == `PDM_TOP_ADDR && d == first_read_value) ?
                             step_o + 3'h1 : 3'h0;
        3'h3, 3'h4: step_o = (wr && a == `PDM_TOP_ADDR) ? step_o + 3'h1 : 3'h0;
        default:
        begin
          if (!wr && a[21] && &a[18:0])
            case (a[20:19])
              2'b11: mode_o = 2'h0;
              2'b10: mode_o = DENSITY_64M ? mode_o : 2'h1;
              2'b01: mode_o = DENSITY_64M ? 2'h1 : 2'h2;
              default: mode_o = DENSITY_64M ? 2'h2 : mode_o;
            endcase
          step_o = 3'h0;
        end
      endcase
    end
    // entry: sleep loses all, a partial mode keeps its low range
    if (ppd && !pds_i)
    begin
      err_o = err_o | !cs_n_i;
      q.delete();
      foreach (mem[k])
        if (mode_o == 2'h0 || k > lim(mode_o))
          q.push_back(k);
      foreach (q[i])
        mem.delete(q[i]);
    end
    {pcs, ppd} = {cs_n_i, pds_i};
  end
endmodule // pdm_mem_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
`include "pdm_cfg.svh"
// ==========================================================================
// controller against the behavioural memory
module tb_top;
  import pdm_pkg::*;
  localparam logic [21:0] TOP = `PDM_TOP_ADDR;
  pdm_mode_t   ms[3] = '{MODE_PART_A, MODE_PART_B, MODE_SLEEP};  // order of programming
  logic        sys_clk_i = 1'b0, rstn_i = 1'b0, cmd_valid_i = 1'b0;
  pdm_op_t     cmd_op_i = OP_READ;
  logic [21:0] cmd_addr_i = 22'h00_0000, mem_addr_o;
  logic [15:0] cmd_wdata_i = 16'h0000, rsp_rdata_o, mem_dq_o, mem_dq_i, mdl_dq;
  pdm_mode_t   cmd_mode_i = MODE_SLEEP, mode_o;
  logic        cmd_ready_o, rsp_valid_o, powered_down_o, chip_select_n_o, mdl_err;
  logic        power_down_select_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o;
  logic [1:0]  mdl_mode;
  logic [2:0]  mdl_step;
  int          failures = 0, comparisons = 0, cycles = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  // host wins the bus only while it drives
  assign mem_dq_i = mem_dq_oe_o ? mem_dq_o : mdl_dq;
  pdm_ctrl #(.DENSITY_64M(1'b1)) dut_u (.sys_clk_i, .rstn_i, .cmd_valid_i, .cmd_ready_o,
    .cmd_op_i, .cmd_addr_i, .cmd_wdata_i, .cmd_mode_i, .rsp_valid_o, .rsp_rdata_o, .mode_o,
    .powered_down_o, .mem_addr_o, .chip_select_n_o, .power_down_select_o, .mem_we_n_o,
    .mem_oe_n_o, .mem_lb_n_o(), .mem_ub_n_o(), .mem_dq_o, .mem_dq_oe_o, .mem_dq_i);
  pdm_mem_model #(.DENSITY_64M(1'b1)) mdl_u (.clk_i(sys_clk_i), .addr_i(mem_addr_o),
    .cs_n_i(chip_select_n_o), .pds_i(power_down_select_o), .we_n_i(mem_we_n_o),
    .oe_n_i(mem_oe_n_o), .dq_i(mem_dq_i), .dq_o(mdl_dq), .mode_o(mdl_mode),
    .step_o(mdl_step), .err_o(mdl_err));
  // ==========================================================================
  // shared helpers
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // offer a command and hold it until the edge that takes it
  task automatic cmd(input pdm_op_t op, input logic [21:0] ad, input logic [15:0] wd,
                     input pdm_mode_t m);
    int n = 0;
    @(posedge sys_clk_i);
    {cmd_valid_i, cmd_addr_i, cmd_wdata_i} <= {1'b1, ad, wd};
    cmd_op_i   <= op;
    cmd_mode_i <= m;
    do
      @(negedge sys_clk_i);
    while (cmd_ready_o !== 1'b1 && ++n < 100);
    chk("cmd_ready_o", cmd_ready_o, 1'b1);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
  endtask
  // bounded wait for the one-cycle response
  task automatic rsp();
    int n = 0;
    do
      @(negedge sys_clk_i);
    while (rsp_valid_o !== 1'b1 && ++n < 100);
    chk("rsp_valid_o", rsp_valid_o, 1'b1);
  endtask
  task automatic wr(input logic [21:0] ad, input logic [15:0] wd);
    cmd(OP_WRITE, ad, wd, MODE_SLEEP);
    rsp();
  endtask
  task automatic rd(input logic [21:0] ad, input logic [15:0] e);
    cmd(OP_READ, ad, 16'h0000, MODE_SLEEP);
    rsp();
    chk("rsp_rdata_o", rsp_rdata_o, e);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk("mode_o", mode_o, MODE_SLEEP);
    chk("mdl_mode", mdl_mode, 2'h0);
    chk("powered_down_o", powered_down_o, 1'b0);
    chk("power_down_select_o", power_down_select_o, 1'b1);
    $display("test reset done");
  endtask
  // back-to-back accesses, standby between each
  task automatic t_access();
    wr(22'h00_0010, 16'hBEEF);
    wr(TOP, 16'h1234);
    rd(22'h00_0010, 16'hBEEF);
    rd(TOP, 16'h1234);
    $display("test access done");
  endtask
  // each 64M mode key, key word returned, top word written back
  task automatic t_program();
    logic [21:0] ks[3] = '{`PDM_KEY_8M, `PDM_KEY_16M, `PDM_KEY_SLEEP};
    logic [15:0] ev[3] = '{16'h5A01, 16'h5A02, 16'h1234};
    for (int i = 0; i < 3; i++)
    begin
      wr(ks[i], ev[i]);
      cmd(OP_PROGRAM, 22'h00_0000, 16'h0000, ms[i]);
      rsp();
      chk("key_read_value", rsp_rdata_o, ev[i]);
      chk("mode_o", mode_o, ms[i]);
      chk("mdl_mode", mdl_mode, ms[i]);
      chk("mdl_step", mdl_step, 3'h0);
      rd(TOP, 16'h1234);
    end
    $display("test program done");
  endtask
  // program first, then data, power-down, refusal, wake, read back
  task automatic t_retain();
    logic [21:0] lm[3] = '{22'h07_FFFF, 22'h0F_FFFF, 22'h07_FFFF};
    logic        kp[3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++)
    begin
      cmd(OP_PROGRAM, 22'h00_0000, 16'h0000, ms[i]);
      rsp();
      wr(22'h00_0000, 16'hC001);
      wr(lm[i], 16'hC002);
      wr(lm[i] + 22'h1, 16'hC003);
      cmd(OP_SLEEP, 22'h00_0000, 16'h0000, MODE_SLEEP);
      @(negedge sys_clk_i);
      chk("powered_down_o", powered_down_o, 1'b1);
      chk("power_down_select_o", power_down_select_o, 1'b0);
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b1;
      repeat (3)
      begin
        @(negedge sys_clk_i);
        chk("cmd_ready_o", cmd_ready_o, 1'b0);
      end
      cmd(OP_WAKE, 22'h00_0000, 16'h0000, MODE_SLEEP);
      rd(22'h00_0000, kp[i] ? 16'hC001 : 16'h0000);
      rd(lm[i], kp[i] ? 16'hC002 : 16'h0000);
      rd(lm[i] + 22'h1, 16'h0000);
      chk("mdl_err", mdl_err, 1'b0);
    end
    $display("test retain done");
  endtask
  // ==========================================================================
  // verdict and run control
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ceiling far above the fewer than one thousand cycles the tests need
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(negedge sys_clk_i);
    t_reset();
    t_access();
    t_program();
    t_retain();
    print_verdict();
  end
endmodule // tb_top
